// file: rtl/angle_status_pkg.sv
package angle_status_pkg;

   // Command codes
   localparam logic [7:0] cmd_multi_turn   = 8'h92;
   localparam logic [7:0] cmd_single_turn  = 8'h94;
   localparam logic [7:0] cmd_status_one   = 8'h9a;

   // Link framing
   localparam logic [10:0] can_reply_offset = 11'h100;
   localparam logic [10:0] can_request_base = 11'h140;
   localparam logic [7:0]  frame_header     = 8'h3e;
   localparam logic [7:0]  frame_length     = 8'h08;
   localparam logic [15:0] crc_init         = 16'hffff;
   localparam logic [15:0] crc_poly_rev     = 16'ha001;

   // Single-turn range
   localparam logic [15:0] single_turn_max  = 16'h8c9f;

   // Fault bit positions
   localparam int fault_stall_pos      = 1;
   localparam int fault_undervolt_pos  = 2;
   localparam int fault_overvolt_pos   = 3;
   localparam int fault_overcur_pos    = 4;
   localparam int fault_power_pos      = 6;
   localparam int fault_calwrite_pos   = 7;
   localparam int fault_overspeed_pos  = 8;
   localparam int fault_overtemp_pos   = 12;
   localparam int fault_enccal_pos     = 13;
   localparam int fault_count          = 9;
   localparam int fault_pos_table [fault_count] = '{1, 2, 3, 4, 6, 7, 8, 12, 13};

   // APB register byte offsets
   localparam logic [7:0] reg_status_off   = 8'h00;
   localparam logic [7:0] reg_mask_off     = 8'h04;
   localparam logic [7:0] reg_control_off  = 8'h08;
   localparam logic [7:0] reg_count_off    = 8'h0c;
   localparam logic [7:0] reg_fault_off    = 8'h10;

   // Reset values
   localparam logic [2:0]  status_reset    = 3'h0;
   localparam logic [2:0]  mask_reset      = 3'h0;
   localparam logic [7:0]  control_reset   = 8'h01;
   localparam logic [15:0] count_reset     = 16'h0000;

   // Status bit positions
   localparam int ev_reply_pos    = 0;
   localparam int ev_unknown_pos  = 1;
   localparam int ev_fault_pos    = 2;

   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_build = 2'b01,
      st_crc   = 2'b10,
      st_out   = 2'b11
   } reply_state_type;

endpackage

// file: rtl/crc16_step.sv
module crc16_step
   import angle_status_pkg::*;
(
   // Running value and new byte
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  data_in,
   // Updated value
   output logic      [15:0] crc_out
);

   logic [15:0] stage [9];

   assign stage[0] = crc_in ^ {8'h00, data_in};

   // Reflected polynomial, one bit per stage
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ crc_poly_rev) : (stage[i] >> 1);
      end
   endgenerate

   assign crc_out = stage[8];

endmodule // crc16_step

// file: rtl/motor_angle_status_replier.sv
// Implementation choices: the address map and the APB slave port.
module motor_angle_status_replier
   import angle_status_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   // Request from link receiver
   input  wire logic        req_valid,
   input  wire logic [10:0] req_can_id,
   input  wire logic [7:0]  req_data [8],
   // Motor measurements
   input  wire logic [31:0] multi_turn_angle,
   input  wire logic [15:0] single_turn_angle,
   input  wire logic [7:0]  motor_temp,
   input  wire logic [7:0]  mos_temp,
   input  wire logic        brake_command_state,
   input  wire logic [15:0] supply_voltage,
   input  wire logic [fault_count-1:0] fault_flags,
   // Reply frame
   output logic             reply_valid,
   output logic [10:0]      reply_can_id,
   output logic [7:0]       reply_data [8],
   output logic [7:0]       reply_header,
   output logic [7:0]       reply_motor_id,
   output logic [7:0]       reply_length,
   output logic [7:0]       reply_crc_low,
   output logic [7:0]       reply_crc_high
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   reply_state_type state_reg, state_next;
   logic [7:0]  data_reg [8];
   logic [7:0]  cmd_reg;
   logic [10:0] id_reg;
   logic [3:0]  crc_idx_reg;
   logic [15:0] crc_reg;
   logic [2:0]  status_reg;
   logic [2:0]  mask_reg;
   logic [7:0]  control_reg;
   logic [15:0] count_reg;
   logic [31:0] prdata_reg;
   logic        irq_reg;
   logic        valid_reg;
   logic        pready_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Fault word assembly

   logic [15:0] fault_word;

   // Each flag lands on its own bit, so faults superimpose
   genvar f;
   generate
      for (f = 0; f < 16; f++) begin : g_fault
         if (f == fault_stall_pos) begin : g_s
            assign fault_word[f] = fault_flags[0];
         end else if (f == fault_undervolt_pos) begin : g_u
            assign fault_word[f] = fault_flags[1];
         end else if (f == fault_overvolt_pos) begin : g_o
            assign fault_word[f] = fault_flags[2];
         end else if (f == fault_overcur_pos) begin : g_c
            assign fault_word[f] = fault_flags[3];
         end else if (f == fault_power_pos) begin : g_p
            assign fault_word[f] = fault_flags[4];
         end else if (f == fault_calwrite_pos) begin : g_w
            assign fault_word[f] = fault_flags[5];
         end else if (f == fault_overspeed_pos) begin : g_v
            assign fault_word[f] = fault_flags[6];
         end else if (f == fault_overtemp_pos) begin : g_t
            assign fault_word[f] = fault_flags[7];
         end else if (f == fault_enccal_pos) begin : g_e
            assign fault_word[f] = fault_flags[8];
         end else begin : g_z
            assign fault_word[f] = 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Request decode

   wire         enable_bit   = control_reg[0];
   wire         strict_bit   = control_reg[1];
   wire [7:0]   cmd          = req_data[0];
   wire         tail_zero    = (req_data[1] | req_data[2] | req_data[3] | req_data[4] |
                                req_data[5] | req_data[6] | req_data[7]) == 8'h00;
   wire         known_cmd    = (cmd == cmd_multi_turn) || (cmd == cmd_single_turn) ||
                               (cmd == cmd_status_one);
   wire         accept       = req_valid && enable_bit && (state_reg == st_idle) &&
                               known_cmd && (tail_zero || !strict_bit);
   wire         reject       = req_valid && enable_bit && (state_reg == st_idle) && !accept;
   // Out-of-range single-turn input is wrapped so the reply stays in range
   wire [15:0]  single_wrap  = (single_turn_angle > single_turn_max) ?
                               16'(single_turn_angle - (single_turn_max + 16'h0001)) :
                               single_turn_angle;
   wire [31:0]  multi_signed = $signed(multi_turn_angle);

   logic [7:0] build [8];
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         build[k] = 8'h00;
      end
      build[0] = cmd_reg;
      case (cmd_reg)
         cmd_multi_turn: begin
            build[4] = multi_signed[7:0];
            build[5] = multi_signed[15:8];
            build[6] = multi_signed[23:16];
            build[7] = multi_signed[31:24];
         end
         cmd_single_turn: begin
            build[6] = single_wrap[7:0];
            build[7] = single_wrap[15:8];
         end
         cmd_status_one: begin
            build[1] = motor_temp;
            build[2] = mos_temp;
            build[3] = {7'h00, brake_command_state};
            build[4] = supply_voltage[7:0];
            build[5] = supply_voltage[15:8];
            build[6] = fault_word[7:0];
            build[7] = fault_word[15:8];
         end
         default: begin
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // CRC over header, ID, length and data

   wire [7:0]  motor_id   = control_reg[7:0] == 8'h00 ? 8'h00 : 8'(id_reg - can_request_base);
   logic [7:0] crc_byte;
   logic [15:0] crc_step;

   always_comb begin
      case (crc_idx_reg)
         4'h0: crc_byte = frame_header;
         4'h1: crc_byte = motor_id;
         4'h2: crc_byte = frame_length;
         default: crc_byte = data_reg[3'(crc_idx_reg - 4'h3)];
      endcase
   end

   crc16_step u_crc (
      .crc_in  (crc_reg),
      .data_in (crc_byte),
      .crc_out (crc_step)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reply sequencer

   wire crc_last = (crc_idx_reg == 4'ha);

   always_comb begin
      case (state_reg)
         st_idle:  state_next = accept ? st_build : st_idle;
         st_build: state_next = st_crc;
         st_crc:   state_next = crc_last ? st_out : st_crc;
         st_out:   state_next = st_idle;
         default:  state_next = st_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= st_idle;
         cmd_reg     <= 8'h00;
         id_reg      <= 11'h000;
         crc_idx_reg <= 4'h0;
         crc_reg     <= crc_init;
         valid_reg   <= 1'b0;
         for (int k = 0; k < 8; k++) data_reg[k] <= 8'h00;
      end else begin
         state_reg <= state_next;
         valid_reg <= (state_reg == st_out);
         if (accept) begin
            cmd_reg <= cmd;
            id_reg  <= req_can_id;
         end
         if (state_reg == st_build) begin
            data_reg    <= build;
            crc_idx_reg <= 4'h0;
            crc_reg     <= crc_init;
         end
         if (state_reg == st_crc) begin
            crc_reg     <= crc_step;
            crc_idx_reg <= crc_idx_reg + 4'h1;
         end
      end
   end

   // Outputs held until the next reply replaces them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_can_id   <= 11'h000;
         reply_header   <= 8'h00;
         reply_motor_id <= 8'h00;
         reply_length   <= 8'h00;
         reply_crc_low  <= 8'h00;
         reply_crc_high <= 8'h00;
         for (int k = 0; k < 8; k++) reply_data[k] <= 8'h00;
      end else if (state_reg == st_out) begin
         reply_can_id   <= 11'(id_reg + can_reply_offset);
         reply_header   <= frame_header;
         reply_motor_id <= motor_id;
         reply_length   <= frame_length;
         reply_crc_low  <= crc_reg[7:0];
         reply_crc_high <= crc_reg[15:8];
         reply_data     <= data_reg;
      end
   end

   assign reply_valid = valid_reg;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave and interrupt

   // One wait state lets read data stand when pready is sampled
   wire       apb_access = psel && penable;
   wire       apb_done   = apb_access && pready_reg;
   wire       apb_wr     = apb_done && pwrite;
   wire       apb_rd     = apb_access && !pwrite && !pready_reg;
   wire       hit_status = paddr == reg_status_off;
   wire       hit_mask   = paddr == reg_mask_off;
   wire       hit_ctrl   = paddr == reg_control_off;
   wire       hit_count  = paddr == reg_count_off;
   wire       hit_fault  = paddr == reg_fault_off;
   wire       mapped     = hit_status | hit_mask | hit_ctrl | hit_count | hit_fault;
   wire [2:0] ev_set     = {|fault_flags, reject, valid_reg};
   wire [2:0] ev_clr     = (apb_wr && hit_status) ? pwdata[2:0] : 3'h0;
   // Set wins over a same-cycle clear
   wire [2:0] status_next = (status_reg & ~ev_clr) | ev_set;
   wire [31:0] read_mux  = hit_status ? {29'h0, status_reg} :
                           hit_mask   ? {29'h0, mask_reg} :
                           hit_ctrl   ? {24'h0, control_reg} :
                           hit_count  ? {16'h0, count_reg} :
                           hit_fault  ? {16'h0, fault_word} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg  <= status_reset;
         mask_reg    <= mask_reset;
         control_reg <= control_reset;
         count_reg   <= count_reset;
         prdata_reg  <= 32'h0;
         irq_reg     <= 1'b0;
         pready_reg  <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg    <= |(status_next & mask_reg);
         pready_reg <= apb_access && !pready_reg;
         if (apb_wr && hit_mask) mask_reg <= pwdata[2:0];
         if (apb_wr && hit_ctrl) control_reg <= pwdata[7:0];
         if (valid_reg) count_reg <= count_reg + 16'h0001;
         if (apb_rd) prdata_reg <= read_mux;
      end
   end

   // Read data loaded in the first access cycle, ready in the second
   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = 1'b0;
   assign irq     = irq_reg;

   if (fault_count != 9) begin : g_count_check
      $error("fault_count must be 9");
   end

endmodule // motor_angle_status_replier

// file: testbench/motor_angle_status_replier_properties.sv
module motor_angle_status_replier_properties
   import angle_status_pkg::*;
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Request side
   input wire logic        req_valid,
   input wire logic [10:0] req_can_id,
   input wire logic [7:0]  req_data [8],
   // Reply side
   input wire logic        reply_valid,
   input wire logic [10:0] reply_can_id,
   input wire logic [7:0]  reply_data [8],
   input wire logic [7:0]  reply_header,
   input wire logic [7:0]  reply_length
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] hi_word;
   assign hi_word = {reply_data[7], reply_data[6]};
   ////////////////////////////////////////
   a_reply_after_req: assert property (reply_valid |-> $past(req_valid, 14))
      else $error("reply without request");
   a_reply_one_cycle: assert property (reply_valid |=> !reply_valid)
      else $error("reply pulse too long");
   a_echo_command: assert property (reply_valid |-> reply_data[0] == $past(req_data[0], 14))
      else $error("command not echoed");
   a_can_offset: assert property (reply_valid |-> reply_can_id == 11'($past(req_can_id, 14) + can_reply_offset))
      else $error("reply id offset wrong");
   a_frame_fixed: assert property (reply_valid |-> reply_header == frame_header && reply_length == frame_length)
      else $error("frame header or length wrong");
   a_multi_pad: assert property (reply_valid && reply_data[0] == cmd_multi_turn |->
      {reply_data[1], reply_data[2], reply_data[3]} == 24'h0)
      else $error("multi-turn padding nonzero");
   a_single_pad: assert property (reply_valid && reply_data[0] == cmd_single_turn |->
      {reply_data[1], reply_data[2], reply_data[3], reply_data[4], reply_data[5]} == 40'h0)
      else $error("single-turn padding nonzero");
   a_single_range: assert property (reply_valid && reply_data[0] == cmd_single_turn |-> hi_word <= single_turn_max)
      else $error("single-turn angle out of range");
   a_fault_bits: assert property (reply_valid && reply_data[0] == cmd_status_one |-> (hi_word & ~16'h31de) == 16'h0)
      else $error("undefined fault bit set");
   c_multi: cover property (reply_valid && reply_data[0] == cmd_multi_turn);
   c_single: cover property (reply_valid && reply_data[0] == cmd_single_turn);
   c_status: cover property (reply_valid && reply_data[0] == cmd_status_one);
endmodule // motor_angle_status_replier_properties

bind motor_angle_status_replier motor_angle_status_replier_properties i_motor_angle_status_replier_properties (
   .pclk(pclk),
   .presetn(presetn),
   .req_valid(req_valid),
   .req_can_id(req_can_id),
   .req_data(req_data),
   .reply_valid(reply_valid),
   .reply_can_id(reply_can_id),
   .reply_data(reply_data),
   .reply_header(reply_header),
   .reply_length(reply_length)
);

// file: testbench/host_link_model.sv
module host_link_model
   import angle_status_pkg::*;
(
   // Clock
   input  wire logic        pclk,
   // Request to the block
   output logic             req_valid,
   output logic [10:0]      req_can_id,
   output logic [7:0]       req_data [8]
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req_valid = 1'b0;
      req_can_id = 11'h0;
      for (int i = 0; i < 8; i++) req_data[i] = 8'h00;
   end
   ////////////////////////////////////////
   // Tail is zero unless a refusal is wanted
   task automatic send(input logic [7:0] code, input logic [10:0] id, input logic [7:0] tail);
      @(posedge pclk);
      req_valid <= 1'b1;
      req_can_id <= id;
      req_data[0] <= code;
      for (int i = 1; i < 8; i++) req_data[i] <= tail;
      @(posedge pclk);
      req_valid <= 1'b0;
      // Released ID and command lines show junk; the tail bytes keep the old frame
      req_can_id <= ~id;
      req_data[0] <= ~code;
   endtask
endmodule // host_link_model

// file: testbench/tb_motor_angle_status_replier.sv
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_motor_angle_status_replier;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, pready, pslverr, irq, reply_valid, req_valid;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        brake_command_state = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] multi_turn_angle = 32'h0;
   logic [15:0] single_turn_angle = 16'h0;
   logic [15:0] supply_voltage = 16'h0;
   logic [7:0]  motor_temp = 8'h00;
   logic [7:0]  mos_temp = 8'h00;
   logic [8:0]  fault_flags = 9'h0;
   logic [31:0] prdata, q;
   logic [10:0] req_can_id, reply_can_id;
   logic [7:0]  req_data [8], reply_data [8], hdr, mid, len, crc_l, crc_h;
   int          err_total, checks, cycles, nrep;
   motor_angle_status_replier i_motor_angle_status_replier (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .req_valid(req_valid), .req_can_id(req_can_id), .req_data(req_data),
      .multi_turn_angle(multi_turn_angle), .single_turn_angle(single_turn_angle), .motor_temp(motor_temp),
      .mos_temp(mos_temp), .brake_command_state(brake_command_state), .supply_voltage(supply_voltage),
      .fault_flags(fault_flags), .reply_valid(reply_valid), .reply_can_id(reply_can_id),
      .reply_data(reply_data), .reply_header(hdr), .reply_motor_id(mid), .reply_length(len),
      .reply_crc_low(crc_l), .reply_crc_high(crc_h));
   host_link_model i_host_link_model (.pclk(pclk), .req_valid(req_valid), .req_can_id(req_can_id),
      .req_data(req_data));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   ////////////////////////////////////////
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles needed
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         finish_test();
      end
   end
   // Data taken at the edge where pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ask(input logic [7:0] c, input logic [63:0] e);
      logic [15:0] r;
      int          n;
      i_host_link_model.send(c, 11'h141, 8'h00);
      n = 0;
      while (reply_valid !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      `CHK("reply", 1'b1, reply_valid)
      for (int i = 0; i < 8; i++) `CHK("byte", e[8*i+:8], reply_data[i])
      `CHK("can id", 11'h241, reply_can_id)
      `CHK("header", 8'h3e, hdr)
      `CHK("length", 8'h08, len)
      `CHK("motor id", 8'h01, mid)
      r = 16'hffff;
      for (int i = 0; i < 11; i++) begin
         r ^= {8'h00, i == 0 ? 8'h3e : i == 1 ? 8'h01 : i == 2 ? 8'h08 : e[8*(i-3)+:8]};
         for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
      end
      `CHK("crc", r, {crc_h, crc_l})
      nrep++;
   endtask
   ////////////////////////////////////////
   task automatic t_angles;
      multi_turn_angle <= 32'h00008ca0;
      ask(8'h92, {32'h00008ca0, 32'h92});
      multi_turn_angle <= 32'hffff7360;
      ask(8'h92, {32'hffff7360, 32'h92});
      single_turn_angle <= 16'h2710;
      ask(8'h94, {16'h2710, 40'h0, 8'h94});
      single_turn_angle <= 16'h8c9f;
      ask(8'h94, {16'h8c9f, 40'h0, 8'h94});
      single_turn_angle <= 16'h8ca0;
      ask(8'h94, {16'h0000, 40'h0, 8'h94});
   endtask
   task automatic t_status;
      logic [15:0] fw [9];
      fw = '{16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0040, 16'h0080, 16'h0100, 16'h1000, 16'h2000};
      motor_temp <= 8'h32;
      mos_temp <= 8'hce;
      supply_voltage <= 16'h01e5;
      for (int i = 0; i < 9; i++) begin
         fault_flags <= 9'(1 << i);
         brake_command_state <= i[0];
         ask(8'h9a, {fw[i], 16'h01e5, 7'h0, i[0], 8'hce, 8'h32, 8'h9a});
      end
      fault_flags <= 9'h1ff;
      ask(8'h9a, {16'h31de, 16'h01e5, 8'h00, 8'hce, 8'h32, 8'h9a});
   endtask
   task automatic t_regs;
      fault_flags <= 9'h0;
      apb(1'b0, 8'h08, 32'h0);
      `CHK("control", 32'h1, q)
      apb(1'b0, 8'h0c, 32'h0);
      `CHK("count", 32'(nrep), q)
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped", 32'h0, q)
      `CHK("no error", 1'b0, pslverr)
      apb(1'b1, 8'h00, 32'h7);
      apb(1'b1, 8'h04, 32'h1);
      `CHK("irq idle", 1'b0, irq)
      ask(8'h92, {32'hffff7360, 32'h92});
      repeat (3) @(posedge pclk);
      `CHK("irq raised", 1'b1, irq)
      apb(1'b1, 8'h00, 32'h1);
      i_host_link_model.send(8'h55, 11'h141, 8'h00);
      repeat (20) @(posedge pclk);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b0, 8'h00, 32'h0);
      `CHK("refused", 32'h2, q)
      // Strict tail check refuses a nonzero tail
      apb(1'b1, 8'h08, 32'h3);
      apb(1'b1, 8'h00, 32'h7);
      i_host_link_model.send(8'h92, 11'h141, 8'h5a);
      repeat (20) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      `CHK("strict refused", 32'h2, q)
      apb(1'b0, 8'h0c, 32'h0);
      `CHK("no reply", 32'(nrep), q)
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_angles();
      t_status();
      t_regs();
      finish_test();
   end
endmodule // tb_motor_angle_status_replier
